// [inc/actc_pkg.sv]
/*
 * Shared constants and types for the converter clamp timing control block:
 * register offsets, reset values, control bit positions, clamp codes and
 * the carrier structs used between the top level and its users.
 * Assumes a single pixel-rate clock domain and an 8-bit register port.
 */
package actc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_DELAY = 8'h01;
  localparam logic [7:0] OFS_LENGTH = 8'h02;
  localparam logic [7:0] OFS_GAIN_R = 8'h03;
  localparam logic [7:0] OFS_GAIN_G = 8'h04;
  localparam logic [7:0] OFS_GAIN_B = 8'h05;
  localparam logic [7:0] OFS_SHIFT_R = 8'h06;
  localparam logic [7:0] OFS_SHIFT_G = 8'h07;
  localparam logic [7:0] OFS_SHIFT_B = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h09;
  localparam logic [7:0] OFS_MIDSEL = 8'h0F;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_DELAY = 8'h08;
  localparam logic [7:0] RST_LENGTH = 8'h14;
  localparam logic [7:0] RST_GAIN = 8'h80;
  localparam logic [6:0] RST_SHIFT = 7'h40;
  localparam logic [2:0] RST_CTRL = 3'h0;
  localparam logic [2:0] RST_MIDSEL = 3'h0;
  localparam logic signed [7:0] RST_TRIM = 8'sh00;

  // ==========================================================================
  // Control and status register bit positions
  localparam int CTRL_EXT = 0;
  localparam int CTRL_CPOL = 1;
  localparam int CTRL_HPOL = 2;
  localparam int STAT_CLAMP = 0;
  localparam int STAT_LOST = 1;

  // ==========================================================================
  // Clamp targets and analog scaling figures
  localparam logic [7:0] CODE_GROUND = 8'h00;
  localparam logic [7:0] CODE_MID = 8'h10;
  localparam logic [7:0] SHIFT_ZERO = 8'h40;
  localparam logic signed [7:0] SHIFT_LIMIT = 8'sh3F;
  localparam logic [9:0] RANGE_MIN_MV = 10'h1F4;
  localparam logic [17:0] RANGE_SPAN_MV = 18'h001F4;
  localparam logic [11:0] STEP_MIN_UV = 12'h7D0;
  localparam logic [18:0] STEP_SPAN_UV = 19'h007D0;
  localparam logic signed [7:0] TRIM_MAX = 8'sh7F;
  localparam logic signed [7:0] TRIM_MIN = -8'sh7F;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CLAMP = 2'b11
  } actc_state_e;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } actc_rgb_s;

  typedef struct packed {
    logic signed [7:0] r;
    logic signed [7:0] g;
    logic signed [7:0] b;
  } actc_trim_s;

  typedef struct packed {
    logic [9:0] rangeMv;
    logic [11:0] stepUv;
    logic signed [6:0] shiftLsb;
  } actc_chan_s;

endpackage

// [verilog/actc_clamp_timer.sv]
/*
 * Internal clamp timing generator: waits a programmed number of pixel
 * periods after each trailing sync edge, then holds clamp for a programmed
 * number of pixel periods. Expects a one-cycle trailing edge pulse.
 */
`timescale 1ns/10ps
`default_nettype none

module actc_clamp_timer
  import actc_pkg::*;
(
  input wire logic mclk, // pixel clock
  input wire logic nrst, // async reset, active low
  input wire logic trailEdge, // one-cycle trailing sync edge
  input wire logic [7:0] delayCount, // periods before clamp
  input wire logic [7:0] lengthCount, // periods of clamp
  output logic clampOn // internal clamp interval
);

  actc_state_e state;
  logic [7:0] cnt;
  logic [7:0] runCnt;
  logic [7:0] runLen;

  // ==========================================================================
  // Sequencer
  // A new edge always wins, so a clamp still running is cut short here, or restarted at full length when delay is zero.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      cnt <= 8'h00;
    end else if (trailEdge) begin
      if (delayCount == 8'h00 && lengthCount != 8'h00) begin
        state <= ST_CLAMP;
        cnt <= lengthCount - 8'h01;
      end else if (delayCount == 8'h00) begin
        state <= ST_IDLE;
        cnt <= 8'h00;
      end else begin
        state <= ST_WAIT;
        cnt <= delayCount - 8'h01;
      end
    end else begin
      unique case (state)
        ST_IDLE: begin
          cnt <= 8'h00;
        end
        ST_WAIT: begin
          if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end else if (lengthCount != 8'h00) begin
            state <= ST_CLAMP;
            cnt <= lengthCount - 8'h01;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_CLAMP: begin
          if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end else begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          cnt <= 8'h00;
        end
      endcase
    end
  end

  assign clampOn = (state == ST_CLAMP);

  // ==========================================================================
  // Checks
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      runCnt <= 8'h00;
      runLen <= 8'h00;
    end else if (clampOn && state == ST_CLAMP && cnt == runLen - runCnt - 8'h01) begin
      runCnt <= runCnt + 8'h01;
    end else if (!clampOn) begin
      runCnt <= 8'h00;
      runLen <= lengthCount;
    end
  end

  a_start_now: assert property (@(posedge mclk) disable iff (!nrst)
    trailEdge && delayCount == 8'h00 && lengthCount != 8'h00 |=> clampOn)
    else $error("clamp did not start at zero placement");

  a_start_wait: assert property (@(posedge mclk) disable iff (!nrst)
    state == ST_WAIT && cnt == 8'h00 && lengthCount != 8'h00 && !trailEdge |=> clampOn)
    else $error("clamp did not start after placement");

  a_no_early: assert property (@(posedge mclk) disable iff (!nrst)
    trailEdge && delayCount == 8'h02 ##1 !trailEdge |-> !clampOn)
    else $error("clamp started before placement elapsed");

  a_edge_restart: assert property (@(posedge mclk) disable iff (!nrst)
    trailEdge && delayCount != 8'h00 |=> !clampOn)
    else $error("clamp survived a new sync edge");

  a_len_bound: assert property (@(posedge mclk) disable iff (!nrst)
    clampOn && runLen == lengthCount |-> runCnt < runLen)
    else $error("clamp ran longer than its duration");

endmodule

`default_nettype wire

// [verilog/actc_top.sv]
/*
 * Clamp timing and converter setting control for a triple video converter.
 * Holds the settings registers, selects internal or pin-driven clamp timing,
 * and trims each converter's offset toward its ground or midscale target
 * while clamp is active. Assumes sync and clamp pins are asynchronous to
 * mclk and that converter codes arrive on mclk.
 */
`timescale 1ns/10ps
`default_nettype none

module actc_top
  import actc_pkg::*;
#(
  parameter int HSYNC_TIMEOUT = 65536 // cycles without sync before loss
)
(
  input wire logic mclk, // pixel clock
  input wire logic nrst, // async reset, active low
  input wire logic hsyncPin, // horizontal sync pin
  input wire logic clampPin, // external clamp pin
  input wire logic regWrEn, // register write strobe
  input wire logic regRdEn, // register read strobe
  input wire logic [7:0] regAddr, // register offset
  input wire logic [7:0] regWrData, // register write data
  output logic [7:0] regRdData, // register read data, one cycle late
  input wire actc_pkg::actc_rgb_s adcCode, // converter output codes
  output logic clampActive, // clamp interval to the converters
  output actc_pkg::actc_trim_s clampTrim, // clamp offset correction
  output actc_pkg::actc_rgb_s clampTarget, // code each channel clamps to
  output actc_pkg::actc_chan_s chanRed, // red analog settings
  output actc_pkg::actc_chan_s chanGreen, // green analog settings
  output actc_pkg::actc_chan_s chanBlue, // blue analog settings
  output logic hsyncLost // no sync edge within timeout
);

  import actc_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic actc_chan_s chanSettings(input logic [7:0] gain,
                                              input logic [6:0] shift);
    logic [17:0] rangeProd;
    logic [18:0] stepProd;
    logic signed [7:0] s;
    actc_chan_s c;
    rangeProd = 18'(gain) * RANGE_SPAN_MV;
    stepProd = 19'(gain) * STEP_SPAN_UV;
    // Step scales with range so brightness tracks contrast.
    c.rangeMv = RANGE_MIN_MV + rangeProd[17:8];
    c.stepUv = STEP_MIN_UV + stepProd[18:8];
    s = $signed({1'b0, shift}) - $signed(SHIFT_ZERO);
    if (s < -SHIFT_LIMIT) begin
      s = -SHIFT_LIMIT;
    end
    c.shiftLsb = s[6:0];
    return c;
  endfunction

  function automatic logic signed [7:0] trimStep(input logic signed [7:0] trim,
                                                 input logic [7:0] code,
                                                 input logic [7:0] target);
    logic signed [7:0] t;
    t = trim;
    if (code < target && trim != TRIM_MAX) begin
      t = trim + 8'sh01;
    end else if (code > target && trim != TRIM_MIN) begin
      t = trim - 8'sh01;
    end
    return t;
  endfunction

  // Reset image of the analog settings, worked out once so that reset loads constants.
  localparam actc_chan_s CHAN_RST = chanSettings(RST_GAIN, RST_SHIFT);

  // ==========================================================================
  // Registers
  logic [7:0] delayCount;
  logic [7:0] lengthCount;
  logic [7:0] gainR;
  logic [7:0] gainG;
  logic [7:0] gainB;
  logic [6:0] shiftR;
  logic [6:0] shiftG;
  logic [6:0] shiftB;
  logic [2:0] ctrl;
  logic [2:0] midSel;
  logic externalClampSelect;
  logic clampPolHigh;
  logic hsyncInvert;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      delayCount <= RST_DELAY;
      lengthCount <= RST_LENGTH;
    end else if (regWrEn && regAddr == OFS_DELAY) begin
      delayCount <= regWrData;
    end else if (regWrEn && regAddr == OFS_LENGTH) begin
      lengthCount <= regWrData;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gainR <= RST_GAIN;
      gainG <= RST_GAIN;
      gainB <= RST_GAIN;
    end else if (regWrEn) begin
      if (regAddr == OFS_GAIN_R) begin
        gainR <= regWrData;
      end
      if (regAddr == OFS_GAIN_G) begin
        gainG <= regWrData;
      end
      if (regAddr == OFS_GAIN_B) begin
        gainB <= regWrData;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      shiftR <= RST_SHIFT;
      shiftG <= RST_SHIFT;
      shiftB <= RST_SHIFT;
    end else if (regWrEn) begin
      if (regAddr == OFS_SHIFT_R) begin
        shiftR <= regWrData[6:0];
      end
      if (regAddr == OFS_SHIFT_G) begin
        shiftG <= regWrData[6:0];
      end
      if (regAddr == OFS_SHIFT_B) begin
        shiftB <= regWrData[6:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= RST_CTRL;
      midSel <= RST_MIDSEL;
    end else if (regWrEn && regAddr == OFS_CTRL) begin
      ctrl <= regWrData[2:0];
    end else if (regWrEn && regAddr == OFS_MIDSEL) begin
      midSel <= regWrData[2:0];
    end
  end

  assign externalClampSelect = ctrl[CTRL_EXT];
  assign clampPolHigh = ctrl[CTRL_CPOL];
  assign hsyncInvert = ctrl[CTRL_HPOL];

  // Unmapped offsets read as zero; reserved bits read as zero.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      unique case (regAddr)
        OFS_DELAY: regRdData <= delayCount;
        OFS_LENGTH: regRdData <= lengthCount;
        OFS_GAIN_R: regRdData <= gainR;
        OFS_GAIN_G: regRdData <= gainG;
        OFS_GAIN_B: regRdData <= gainB;
        OFS_SHIFT_R: regRdData <= {1'b0, shiftR};
        OFS_SHIFT_G: regRdData <= {1'b0, shiftG};
        OFS_SHIFT_B: regRdData <= {1'b0, shiftB};
        OFS_CTRL: regRdData <= {5'h00, ctrl};
        OFS_MIDSEL: regRdData <= {5'h00, midSel};
        OFS_STATUS: regRdData <= {6'h00, hsyncLost, clampActive};
        default: regRdData <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Pin synchronisers and sync edge
  logic hsMeta;
  logic hsSync;
  logic hsPrev;
  logic clMeta;
  logic clSync;
  logic trailEdge;
  logic clampReq;
  logic intClamp;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hsMeta <= 1'b0;
      hsSync <= 1'b0;
      hsPrev <= 1'b0;
    end else begin
      hsMeta <= hsyncPin;
      hsSync <= hsMeta;
      hsPrev <= hsSync;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clMeta <= 1'b0;
      clSync <= 1'b0;
    end else begin
      clMeta <= clampPin;
      clSync <= clMeta;
    end
  end

  // After optional inversion sync is active high, so its fall is the trailing edge.
  assign trailEdge = (hsPrev ^ hsyncInvert) & ~(hsSync ^ hsyncInvert);
  assign clampReq = clampPolHigh ? clSync : ~clSync;

  actc_clamp_timer u_timer (
    .mclk(mclk),
    .nrst(nrst),
    .trailEdge(trailEdge),
    .delayCount(delayCount),
    .lengthCount(lengthCount),
    .clampOn(intClamp)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clampActive <= 1'b0;
    end else begin
      clampActive <= externalClampSelect ? clampReq : intClamp;
    end
  end

  // ==========================================================================
  // Sync loss watch
  // Internal clamp timing needs sync; software should switch to the pin.
  logic [16:0] idleCnt;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      idleCnt <= 17'h00000;
      hsyncLost <= 1'b0;
    end else if (trailEdge) begin
      idleCnt <= 17'h00000;
      hsyncLost <= 1'b0;
    end else if (idleCnt >= 17'(HSYNC_TIMEOUT - 1)) begin
      hsyncLost <= 1'b1;
    end else begin
      idleCnt <= idleCnt + 17'h00001;
    end
  end

  // ==========================================================================
  // Clamp targets and offset trim
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clampTarget <= '{CODE_GROUND, CODE_GROUND, CODE_GROUND};
    end else begin
      clampTarget.r <= midSel[0] ? CODE_MID : CODE_GROUND;
      clampTarget.g <= midSel[1] ? CODE_MID : CODE_GROUND;
      clampTarget.b <= midSel[2] ? CODE_MID : CODE_GROUND;
    end
  end

  // The trim moves one LSB per clamped pixel, a slow loop that rides out noise.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clampTrim <= '{RST_TRIM, RST_TRIM, RST_TRIM};
    end else if (clampActive) begin
      clampTrim.r <= trimStep(clampTrim.r, adcCode.r, clampTarget.r);
      clampTrim.g <= trimStep(clampTrim.g, adcCode.g, clampTarget.g);
      clampTrim.b <= trimStep(clampTrim.b, adcCode.b, clampTarget.b);
    end
  end

  // ==========================================================================
  // Analog settings
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      chanRed <= CHAN_RST;
      chanGreen <= CHAN_RST;
      chanBlue <= CHAN_RST;
    end else begin
      chanRed <= chanSettings(gainR, shiftR);
      chanGreen <= chanSettings(gainG, shiftG);
      chanBlue <= chanSettings(gainB, shiftB);
    end
  end

  // ==========================================================================
  // Checks
  sequence s_ext_high;
    externalClampSelect && clampPolHigh && clampPin ##1
      (externalClampSelect && clampPolHigh)[*2];
  endsequence

  sequence s_ext_low;
    externalClampSelect && !clampPolHigh && !clampPin ##1
      (externalClampSelect && !clampPolHigh)[*2];
  endsequence

  a_ext_high: assert property (@(posedge mclk) disable iff (!nrst)
    s_ext_high |=> clampActive)
    else $error("pin clamp not followed with high polarity");

  a_ext_low: assert property (@(posedge mclk) disable iff (!nrst)
    s_ext_low |=> clampActive)
    else $error("pin clamp not followed with low polarity");

  a_trim_up: assert property (@(posedge mclk) disable iff (!nrst)
    clampActive && adcCode.r < clampTarget.r && clampTrim.r != TRIM_MAX
      |=> clampTrim.r == $past(clampTrim.r) + 8'sh01)
    else $error("red trim did not rise toward target");

  a_trim_down: assert property (@(posedge mclk) disable iff (!nrst)
    clampActive && midSel[1] && adcCode.g > CODE_MID && clampTrim.g != TRIM_MIN
      |=> clampTrim.g == $past(clampTrim.g) - 8'sh01)
    else $error("green trim did not fall toward midscale");

  a_midsel_write: assert property (@(posedge mclk) disable iff (!nrst)
    regWrEn && regAddr == OFS_MIDSEL |=> ##1 clampTarget.b ==
      ($past(regWrData[2], 2) ? CODE_MID : CODE_GROUND))
    else $error("blue target not set from register bit 2");

  a_shift_span: assert property (@(posedge mclk) disable iff (!nrst)
    chanRed.shiftLsb != 7'sh40)
    else $error("red offset below minus 63");

endmodule

`default_nettype wire

// [sim/actc_source_model.sv]
/*
 * Graphics source model: drives horizontal sync and the external clamp pin.
 * Assumes one bench process calls makeLine, and that the bench sets hpol
 * and cpol only while a glitch on the pin that they affect cannot start a clamp.
 */
`timescale 1ns/10ps
`default_nettype none

module actc_source_model (
  input wire logic mclk, // pixel clock
  input wire logic hpol, // 1 sends sync inverted
  input wire logic cpol, // 1 makes clamp pin active high
  output logic hsyncPin, // sync to the block
  output logic clampPin // clamp request to the block
);
  logic syncOn = 1'b0;
  logic clampOn = 1'b0;

  assign hsyncPin = syncOn ^ hpol;
  assign clampPin = clampOn ~^ cpol;

  // ==========================================================================
  // Line generation
  // A clamp request only ever follows the trailing sync edge, never the tip.
  task automatic makeLine(input int syncLen, input int ofs, input int len);
    @(posedge mclk);
    #1 syncOn = 1'b1;
    repeat (syncLen) @(posedge mclk);
    #1 syncOn = 1'b0;
    if (len > 0) begin
      repeat (ofs) @(posedge mclk);
      #1 clampOn = 1'b1;
      repeat (len) @(posedge mclk);
      #1 clampOn = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// [sim/tb_top.sv]
/*
 * Self-checking bench for the clamp timing control block: register port,
 * clamp timing and trim, clamp targets and analog setting outputs.
 * Assumes the package, the design and the source model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import actc_pkg::*;
  typedef struct {int lo; int hi; int len; bit full;} actc_note_s;
  localparam int LOST_CYC = 600;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  actc_rgb_s adcCode = 24'h052000;
  logic clampActive, hsyncLost, hsyncPin, clampPin;
  actc_trim_s clampTrim;
  actc_rgb_s clampTarget;
  actc_chan_s chanRed, chanGreen, chanBlue;
  logic hpol = 1'b0;
  logic cpol = 1'b0;
  int mismatches = 0;
  int checkCount = 0;
  logic [7:0] rdQ[$];
  actc_note_s noteQ[$];
  actc_note_s n;
  logic [7:0] g, s;
  logic [7:0] offs [11] = '{OFS_DELAY, OFS_LENGTH, OFS_GAIN_R, OFS_GAIN_G, OFS_GAIN_B,
    OFS_SHIFT_R, OFS_SHIFT_G, OFS_SHIFT_B, OFS_CTRL, OFS_MIDSEL, 8'h20};
  logic [7:0] rsts [11] = '{RST_DELAY, RST_LENGTH, RST_GAIN, RST_GAIN, RST_GAIN,
    {1'b0, RST_SHIFT}, {1'b0, RST_SHIFT}, {1'b0, RST_SHIFT}, {5'h00, RST_CTRL},
    {5'h00, RST_MIDSEL}, 8'h00};
  logic [15:0] pl [5] = '{16'h0001, 16'h0203, 16'h0900, 16'h1005, 16'hFFFF};

  always #25 mclk = ~mclk;

  actc_top #(.HSYNC_TIMEOUT(LOST_CYC)) DUT (.mclk(mclk), .nrst(nrst), .hsyncPin(hsyncPin),
    .clampPin(clampPin), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .adcCode(adcCode),
    .clampActive(clampActive), .clampTrim(clampTrim), .clampTarget(clampTarget),
    .chanRed(chanRed), .chanGreen(chanGreen), .chanBlue(chanBlue), .hsyncLost(hsyncLost));

  actc_source_model src (.mclk(mclk), .hpol(hpol), .cpol(cpol), .hsyncPin(hsyncPin),
    .clampPin(clampPin));

  // ==========================================================================
  // Tasks
  task automatic final_report();
    if (mismatches == 0 && checkCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(posedge mclk);
    #1 regWrEn = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    #1 regRdEn = 1'b1;
    regAddr = a;
    rdQ.push_back(e);
    @(posedge mclk);
    #1 regRdEn = 1'b0;
  endtask

  task automatic expectPulse(input int lo, input int hi, input int len, input bit full);
    noteQ.push_back('{lo, hi, len, full});
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge mclk);
  endtask

  function automatic actc_chan_s chanExp(input logic [7:0] gv, input logic [7:0] sv);
    int sh;
    sh = int'(sv[6:0]) - 64;
    if (sh < -63) sh = -63;
    chanExp.rangeMv = 10'(500 + gv * 500 / 256);
    chanExp.stepUv = 12'(2000 + gv * 2000 / 256);
    chanExp.shiftLsb = 7'(sh);
  endfunction

  // ==========================================================================
  // Watcher
  // Rise is counted in edges from the first edge that sees sync ended, so
  // the pipeline latency of the sync path is allowed a small window.
  int since = 0;
  int rise = 0;
  int len = 0;
  logic prevSync = 1'b0;
  logic prevClamp = 1'b0;
  logic rdSeen = 1'b0;
  always @(posedge mclk) begin
    if (rdSeen) chk(rdQ.pop_front(), regRdData);
    rdSeen = regRdEn;
    since = (prevSync && !(hsyncPin ^ hpol)) ? 0 : since + 1;
    prevSync = hsyncPin ^ hpol;
    if (clampActive === 1'b1 && !prevClamp) begin
      rise = since;
      len = 0;
    end
    if (clampActive === 1'b1) len++;
    if (clampActive !== 1'b1 && prevClamp) begin
      if (noteQ.size() == 0) chk(0, 1);
      else begin
        n = noteQ.pop_front();
        chk(1, rise >= n.lo && rise <= n.hi);
        chk(1, n.full ? len == n.len : len < n.len);
      end
    end
    prevClamp = clampActive === 1'b1;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'h275A5B32));
    cycles(8);
    #1 nrst = 1'b1;
    foreach (offs[i]) rd(offs[i], rsts[i]);
    wr(OFS_MIDSEL, 8'h01);
    expectPulse(RST_DELAY + 4, RST_DELAY + 7, RST_LENGTH, 1);
    src.makeLine(3, 0, 0);
    cycles(40);
    chk({RST_LENGTH, 8'(-RST_LENGTH), 8'h00}, clampTrim);
    for (int m = 0; m < 8; m++) begin
      wr(OFS_MIDSEL, 8'(m) | 8'hF8);
      rd(OFS_MIDSEL, 8'(m));
      chk({m[0] ? CODE_MID : CODE_GROUND, m[1] ? CODE_MID : CODE_GROUND,
        m[2] ? CODE_MID : CODE_GROUND}, clampTarget);
    end
    for (int i = 0; i < 6; i++) begin
      g = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      s = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : 8'($urandom);
      for (int c = 0; c < 3; c++) begin
        wr(OFS_GAIN_R + 8'(c), g + 8'(c));
        wr(OFS_SHIFT_R + 8'(c), s + 8'(c));
      end
      cycles(2);
      for (int c = 0; c < 3; c++) begin
        rd(OFS_GAIN_R + 8'(c), g + 8'(c));
        rd(OFS_SHIFT_R + 8'(c), (s + 8'(c)) & 8'h7F);
        chk(chanExp(g + 8'(c), s + 8'(c)),
          c == 0 ? chanRed : c == 1 ? chanGreen : chanBlue);
      end
    end
    // Polarity only changes while duration is zero, so its glitch edge is harmless.
    for (int hp = 0; hp < 2; hp++) begin
      wr(OFS_LENGTH, 8'h00);
      wr(OFS_CTRL, 8'(hp << 2));
      hpol = hp[0];
      cycles(8);
      foreach (pl[i]) begin
        wr(OFS_DELAY, pl[i][15:8]);
        wr(OFS_LENGTH, pl[i][7:0]);
        if (pl[i][7:0] != 0)
          expectPulse(pl[i][15:8] + 4, pl[i][15:8] + 7, pl[i][7:0], 1);
        src.makeLine(2 + hp, 1, 0);
        cycles(pl[i][15:8] + pl[i][7:0] + 20);
      end
    end
    wr(OFS_DELAY, 8'h04);
    wr(OFS_LENGTH, 8'h14);
    expectPulse(8, 11, 20, 0);
    expectPulse(8, 11, 20, 1);
    src.makeLine(2, 1, 0);
    cycles(12);
    src.makeLine(2, 1, 0);
    cycles(15);
    rd(OFS_STATUS, 8'h01);
    cycles(33);
    wr(OFS_DELAY, 8'h28);
    wr(OFS_LENGTH, 8'h03);
    for (int cp = 0; cp < 2; cp++) begin
      wr(OFS_CTRL, 8'(4 | cp << 1));
      cpol = cp[0];
      wr(OFS_CTRL, 8'(5 | cp << 1));
      cycles(4);
      expectPulse(6, 9, 6, 1);
      src.makeLine(3, 4, 6);
      cycles(60);
    end
    wr(OFS_CTRL, 8'h04);
    wr(OFS_LENGTH, 8'h00);
    cycles(LOST_CYC + 20);
    chk(1, hsyncLost);
    rd(OFS_STATUS, 8'h02);
    src.makeLine(2, 1, 0);
    cycles(10);
    chk(0, hsyncLost);
    cycles(5);
    chk(0, noteQ.size());
    final_report();
  end

  initial begin
    #(50 * 12000);
    mismatches++;
    final_report();
  end
endmodule

`default_nettype wire
